// [include/rst_irq_pkg.sv]
// Constants, carriers and state codes for the reset and interrupt sequencer
package rst_irq_pkg;
	// ******************************
	// Register map and fields
	// ******************************
	localparam logic [15:0] WDOG_ADDR = 16'h1ff0;
	localparam logic [15:0] STATUS_ADDR = 16'h1ff4;
	localparam int RESTART_BIT = 0;
	localparam int STAT_IRQ = 0;
	localparam int STAT_TIMER = 1;
	localparam int STAT_STOP = 2;
	localparam int STAT_WAIT = 3;
	localparam int STAT_CAUSE_LSB = 4;
	localparam logic [2:0] CAUSE_POR = 3'h1;
	localparam logic [2:0] CAUSE_EXT = 3'h2;
	localparam logic [2:0] CAUSE_WDOG = 3'h4;
	// ******************************
	// Vectors and reset values
	// ******************************
	localparam logic [15:0] VEC_RESET = 16'h1ffe;
	localparam logic [15:0] VEC_SWI = 16'h1ffc;
	localparam logic [15:0] VEC_EXT = 16'h1ffa;
	localparam logic [15:0] VEC_TIMER = 16'h1ff8;
	localparam logic [7:0] SP_RESET = 8'hff;
	localparam logic [7:0] STACK_PAGE = 8'h00;
	localparam logic [15:0] TIMER_PRESET = 16'hfffc;
	localparam int MASK_BIT = 3;
	// ******************************
	// Timing
	// ******************************
	localparam longint CLK_HZ = 40000000;
	localparam logic [11:0] POR_CYCLES = 12'hfe0;
	localparam longint WDOG_TIMEOUT_MS = 64;
	localparam int WDOG_CYCLES_DFLT = int'(CLK_HZ / 1000 * WDOG_TIMEOUT_MS);
	localparam int WDOG_W = 22;
	// ******************************
	// Carriers
	// ******************************
	typedef struct packed {
		logic [15:0] pc;
		logic [7:0] x;
		logic [7:0] a;
		logic [7:0] condition_code_reg;
	} cpu_regs_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} mem_req_s;
	typedef struct packed {
		logic core_reset;
		logic ddr_clear;
		logic timer_clear;
		logic [15:0] timer_preset;
	} reset_ctrl_s;
	typedef enum logic [14:0] {
		ST_IDLE = 15'h0001,
		ST_RESET = 15'h0002,
		ST_PUSH_PCL = 15'h0004,
		ST_PUSH_PCH = 15'h0008,
		ST_PUSH_X = 15'h0010,
		ST_PUSH_A = 15'h0020,
		ST_PUSH_CCR = 15'h0040,
		ST_VEC_HI = 15'h0080,
		ST_VEC_LO = 15'h0100,
		ST_PULL_CCR = 15'h0200,
		ST_PULL_A = 15'h0400,
		ST_PULL_X = 15'h0800,
		ST_PULL_PCH = 15'h1000,
		ST_PULL_PCL = 15'h2000,
		ST_SPARE = 15'h4000
	} seq_e;
endpackage

// [rtl/reset_and_interrupt_sequencer.sv]
// Reset sources, exception sequencing, stacking and vector fetch with APB access
// Behaviour
// - reset clears all port direction bits
// - reset loads stack pointer with FF
// - reset sets the interrupt mask bit
// - reset clears prescaler, presets timer, clears enables
// - reset clears stop and wait latches
// - reset exit fetches PC from 1FFE/1FFF
// - power-up holds reset 4064 cycles, pin only while held low
// - reset pin low two samples resets
// - reset pin is input only
// - watchdog timeout resets like power-on
// - writing zero to restart bit clears watchdog
// - watchdog address reads program memory byte
// - interrupts checked only at instruction end
// - timer interrupt needs clear mask, flag, enable
// - push PROG_COUNTER_LOW, PROG_COUNTER_HIGH, X, A, CONDITION_CODE_REG
// - entry sets mask then fetches vector
// - return pulls CONDITION_CODE_REG, A, X, PROG_COUNTER_HIGH, PROG_COUNTER_LOW
// - external beats timer when both pending
// - software trap ignores mask, vector 1FFC
// - falling request sets latch, cleared at fetch
// - option selects edge or edge-and-level trigger
`timescale 1ns/1ps
module reset_and_interrupt_sequencer
	import rst_irq_pkg::*;
#(
	parameter int WDOG_CYCLES = WDOG_CYCLES_DFLT,
	parameter bit WDOG_PRESENT = 1'b1,
	parameter bit LEVEL_TRIG = 1'b1
) (
	input wire logic pclk, // Bus and core clock
	input wire logic presetn, // Power-on reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [15:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic osc_running, // Oscillator active
	input wire logic ext_reset_n, // Reset pin level
	input wire logic irq_n, // External request pin level
	input wire logic [7:0] rom_wdog_byte, // Program memory at watchdog address
	input wire logic instr_done, // Instruction boundary pulse
	input wire logic trap_instr, // Software trap completing
	input wire logic return_instr, // Return from trap completing
	input wire rst_irq_pkg::cpu_regs_s cpu_regs, // Live core registers
	input wire logic [2:0] timer_flags, // Capture, compare, overflow flags
	input wire logic [2:0] timer_enables, // Matching enables
	input wire logic stop_enter, // Stop instruction pulse
	input wire logic wait_enter, // Wait instruction pulse
	input wire logic [7:0] mem_rdata, // Memory read data
	output rst_irq_pkg::mem_req_s mem_req, // Memory request
	output rst_irq_pkg::reset_ctrl_s reset_ctrl, // Reset side effects
	output logic cpu_hold, // Core stalled by sequencer
	output logic [7:0] sp, // Stack pointer
	output logic mask_set, // Set interrupt mask pulse
	output logic pc_load, // Load PC pulse
	output logic [15:0] new_pc, // PC value to load
	output logic restore_load, // Load pulled registers pulse
	output rst_irq_pkg::cpu_regs_s restore_regs, // Pulled register values
	output logic clocks_stopped, // Stop latch
	output logic cpu_waiting // Wait latch
);
	import rst_irq_pkg::*;

	// ******************************
	// Reset sources
	// ******************************
	logic [1:0] ext_sync_ff;
	logic ext_prev_ff;
	logic ext_s;
	logic ext_low;
	logic [11:0] por_cnt_ff;
	logic por_busy;
	logic [WDOG_W-1:0] wdog_cnt_ff;
	logic wdog_fire;
	logic wdog_wr_clear;
	logic rst_active;
	logic [2:0] cause_ff;

	// Pin only sampled, never driven
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_sync_ff <= 2'h3;
			ext_prev_ff <= 1'b1;
		end
		else
		begin
			ext_sync_ff <= {ext_sync_ff[0], ext_reset_n};
			ext_prev_ff <= ext_sync_ff[1];
		end
	end
	assign ext_s = ext_sync_ff[1];
	assign ext_low = !ext_s && !ext_prev_ff;

	// Stabilisation delay, restarted by watchdog
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			por_cnt_ff <= 12'h000;
		else if (wdog_fire)
			por_cnt_ff <= 12'h000;
		else if (por_busy && osc_running)
			por_cnt_ff <= por_cnt_ff + 12'h001;
	end
	assign por_busy = (por_cnt_ff != POR_CYCLES);
	assign rst_active = por_busy || ext_low;

	assign wdog_wr_clear = psel && penable && pwrite && (paddr == WDOG_ADDR)
		&& !pwdata[RESTART_BIT];
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdog_cnt_ff <= '0;
		else if (rst_active || wdog_wr_clear || !WDOG_PRESENT)
			wdog_cnt_ff <= '0;
		else
			wdog_cnt_ff <= wdog_cnt_ff + {{(WDOG_W-1){1'b0}}, 1'b1};
	end
	assign wdog_fire = WDOG_PRESENT && (wdog_cnt_ff == WDOG_W'(WDOG_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause_ff <= CAUSE_POR;
		else if (wdog_fire)
			cause_ff <= CAUSE_WDOG;
		else if (ext_low)
			cause_ff <= CAUSE_EXT;
	end

	// ******************************
	// Interrupt qualification
	// ******************************
	logic [1:0] irq_sync_ff;
	logic irq_prev_ff;
	logic irq_s;
	logic irq_fall;
	logic irq_latch_ff;
	logic ext_pend;
	logic timer_pend;
	logic mask;
	seq_e state_ff;
	seq_e nxt_state;
	logic [15:0] vec_ff;
	logic [15:0] nxt_vec;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_sync_ff <= 2'h3;
			irq_prev_ff <= 1'b1;
		end
		else
		begin
			irq_sync_ff <= {irq_sync_ff[0], irq_n};
			irq_prev_ff <= irq_sync_ff[1];
		end
	end
	assign irq_s = irq_sync_ff[1];
	assign irq_fall = irq_prev_ff && !irq_s;

	// New edge wins over the fetch clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_latch_ff <= 1'b0;
		else if (rst_active)
			irq_latch_ff <= 1'b0;
		else if (irq_fall)
			irq_latch_ff <= 1'b1;
		else if (state_ff == ST_VEC_HI && vec_ff == VEC_EXT)
			irq_latch_ff <= 1'b0;
	end
	assign ext_pend = irq_latch_ff || (LEVEL_TRIG && !irq_s);
	assign timer_pend = |(timer_flags & timer_enables);
	assign mask = cpu_regs.condition_code_reg[MASK_BIT];

	// ******************************
	// Sequencer
	// ******************************
	always_comb
	begin
		nxt_state = state_ff;
		nxt_vec = vec_ff;
		case (state_ff)
			ST_IDLE:
				if (instr_done)
				begin
					if (return_instr)
						nxt_state = ST_PULL_CCR;
					else if (trap_instr)
					begin
						nxt_state = ST_PUSH_PCL;
						nxt_vec = VEC_SWI;
					end
					else if (ext_pend && !mask)
					begin
						nxt_state = ST_PUSH_PCL;
						nxt_vec = VEC_EXT;
					end
					else if (timer_pend && !mask)
					begin
						nxt_state = ST_PUSH_PCL;
						nxt_vec = VEC_TIMER;
					end
				end
			ST_RESET: nxt_state = ST_VEC_HI;
			ST_PUSH_PCL: nxt_state = ST_PUSH_PCH;
			ST_PUSH_PCH: nxt_state = ST_PUSH_X;
			ST_PUSH_X: nxt_state = ST_PUSH_A;
			ST_PUSH_A: nxt_state = ST_PUSH_CCR;
			ST_PUSH_CCR: nxt_state = ST_VEC_HI;
			ST_VEC_HI: nxt_state = ST_VEC_LO;
			ST_VEC_LO: nxt_state = ST_IDLE;
			ST_PULL_CCR: nxt_state = ST_PULL_A;
			ST_PULL_A: nxt_state = ST_PULL_X;
			ST_PULL_X: nxt_state = ST_PULL_PCH;
			ST_PULL_PCH: nxt_state = ST_PULL_PCL;
			ST_PULL_PCL: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
		if (rst_active)
		begin
			nxt_state = ST_RESET;
			nxt_vec = VEC_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_RESET;
			vec_ff <= VEC_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
			vec_ff <= nxt_vec;
		end
	end
	assign cpu_hold = (state_ff != ST_IDLE);

	// ******************************
	// Stack and memory traffic
	// ******************************
	cpu_regs_s saved_ff;
	logic [7:0] sp_ff;
	logic [7:0] sp_inc;

	assign sp_inc = sp_ff + 8'h01;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			saved_ff <= '0;
		else if (state_ff == ST_IDLE)
			saved_ff <= cpu_regs;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sp_ff <= SP_RESET;
		else if (rst_active)
			sp_ff <= SP_RESET;
		else if (mem_req.we)
			sp_ff <= sp_ff - 8'h01;
		else if (mem_req.re && state_ff != ST_VEC_HI && state_ff != ST_VEC_LO)
			sp_ff <= sp_inc;
	end
	assign sp = sp_ff;

	always_comb
	begin
		mem_req = '0;
		case (state_ff)
			ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_X, ST_PUSH_A, ST_PUSH_CCR:
			begin
				mem_req.addr = {STACK_PAGE, sp_ff};
				mem_req.we = 1'b1;
			end
			ST_PULL_CCR, ST_PULL_A, ST_PULL_X, ST_PULL_PCH, ST_PULL_PCL:
			begin
				mem_req.addr = {STACK_PAGE, sp_inc};
				mem_req.re = 1'b1;
			end
			ST_VEC_HI:
			begin
				mem_req.addr = vec_ff;
				mem_req.re = 1'b1;
			end
			ST_VEC_LO:
			begin
				mem_req.addr = vec_ff + 16'h0001;
				mem_req.re = 1'b1;
			end
			default: mem_req.addr = '0;
		endcase
		case (state_ff)
			ST_PUSH_PCL: mem_req.wdata = saved_ff.pc[7:0];
			ST_PUSH_PCH: mem_req.wdata = saved_ff.pc[15:8];
			ST_PUSH_X: mem_req.wdata = saved_ff.x;
			ST_PUSH_A: mem_req.wdata = saved_ff.a;
			ST_PUSH_CCR: mem_req.wdata = saved_ff.condition_code_reg;
			default: mem_req.wdata = 8'h00;
		endcase
	end

	// Pulled registers and vector capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			restore_regs <= '0;
			new_pc <= '0;
		end
		else
		begin
			case (state_ff)
				ST_PULL_CCR: restore_regs.condition_code_reg <= mem_rdata;
				ST_PULL_A: restore_regs.a <= mem_rdata;
				ST_PULL_X: restore_regs.x <= mem_rdata;
				ST_PULL_PCH: restore_regs.pc[15:8] <= mem_rdata;
				ST_PULL_PCL: restore_regs.pc[7:0] <= mem_rdata;
				ST_VEC_HI: new_pc[15:8] <= mem_rdata;
				ST_VEC_LO: new_pc[7:0] <= mem_rdata;
				default: new_pc <= new_pc;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_load <= 1'b0;
			restore_load <= 1'b0;
			mask_set <= 1'b1;
		end
		else
		begin
			pc_load <= (state_ff == ST_VEC_LO) && !rst_active;
			restore_load <= (state_ff == ST_PULL_PCL) && !rst_active;
			mask_set <= rst_active || (state_ff == ST_PUSH_CCR);
		end
	end

	// ******************************
	// Reset side effects and latches
	// ******************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reset_ctrl <= {1'b1, 1'b1, 1'b1, TIMER_PRESET};
		end
		else
		begin
			reset_ctrl.core_reset <= rst_active;
			reset_ctrl.ddr_clear <= rst_active;
			reset_ctrl.timer_clear <= rst_active;
			reset_ctrl.timer_preset <= TIMER_PRESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clocks_stopped <= 1'b0;
			cpu_waiting <= 1'b0;
		end
		else if (rst_active)
		begin
			clocks_stopped <= 1'b0;
			cpu_waiting <= 1'b0;
		end
		else
		begin
			if (stop_enter)
				clocks_stopped <= 1'b1;
			else if (irq_fall)
				clocks_stopped <= 1'b0;
			if (wait_enter)
				cpu_waiting <= 1'b1;
			else if (state_ff == ST_PUSH_PCL)
				cpu_waiting <= 1'b0;
		end
	end

	// ******************************
	// APB slave
	// ******************************
	logic mapped;
	logic [31:0] status_word;

	assign mapped = (paddr == WDOG_ADDR) || (paddr == STATUS_ADDR);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always_comb
	begin
		status_word = '0;
		status_word[STAT_IRQ] = irq_latch_ff;
		status_word[STAT_TIMER] = timer_pend;
		status_word[STAT_STOP] = clocks_stopped;
		status_word[STAT_WAIT] = cpu_waiting;
		status_word[STAT_CAUSE_LSB +: 3] = cause_ff;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
		begin
			if (paddr == WDOG_ADDR)
				prdata <= {24'h000000, rom_wdog_byte};
			else if (paddr == STATUS_ADDR)
				prdata <= status_word;
			else
				prdata <= '0;
		end
	end

	// ******************************
	// Checks
	// ******************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_SP_RESET: assert property (rst_active |=> sp_ff == SP_RESET)
		else $error("stack pointer not FF after reset");
	AST_POR_HOLD: assert property (por_busy |=> state_ff == ST_RESET)
		else $error("reset released during power-up delay");
	AST_EXT_RST: assert property (!ext_s ##1 !ext_s |=> reset_ctrl.core_reset)
		else $error("reset pin low two samples ignored");
	AST_WDOG_CLEAR: assert property (wdog_wr_clear && !rst_active |=> wdog_cnt_ff == '0)
		else $error("watchdog not restarted");
	AST_NO_ABORT: assert property (state_ff == ST_IDLE && !instr_done && !rst_active
		|=> state_ff == ST_IDLE)
		else $error("exception taken mid instruction");
	AST_TIMER_MASKED: assert property (state_ff == ST_IDLE && instr_done && mask
		&& !trap_instr && !return_instr && !rst_active |=> state_ff == ST_IDLE)
		else $error("interrupt taken with mask set");
	AST_PUSH_ORDER: assert property (state_ff == ST_PUSH_PCL && !por_busy && ext_s
		|-> ##4 (mem_req.we && mem_req.wdata == saved_ff.condition_code_reg))
		else $error("condition codes not pushed fifth");
	AST_EXT_PRIO: assert property (state_ff == ST_IDLE && instr_done && ext_pend
		&& timer_pend && !mask && !trap_instr && !return_instr && !rst_active
		|=> vec_ff == VEC_EXT)
		else $error("timer served before external");
	AST_SWI_ALWAYS: assert property (state_ff == ST_IDLE && instr_done && trap_instr
		&& !return_instr && !rst_active |=> vec_ff == VEC_SWI)
		else $error("software trap not taken");
	AST_RTI_LEN: assert property (state_ff == ST_PULL_CCR && !rst_active
		|=> (!rst_active throughout (1'b1 [*5])) |-> restore_load)
		else $error("return sequence wrong length");
	AST_LATCH_CLR: assert property (state_ff == ST_VEC_HI && vec_ff == VEC_EXT
		&& !irq_fall |=> !irq_latch_ff)
		else $error("request latch not cleared at fetch");

	COV_EXT_IRQ: cover property (state_ff == ST_VEC_HI && vec_ff == VEC_EXT);
	COV_RETURN: cover property (restore_load);
	COV_WDOG_RST: cover property (wdog_fire ##[1:5] state_ff == ST_RESET);
endmodule

// [test/cpu_mem_model.sv]
// Behavioural memory on the far side of the sequencer
`timescale 1ns/1ps
module cpu_mem_model
	import rst_irq_pkg::*;
(
	input wire logic pclk, // Core clock
	input wire rst_irq_pkg::mem_req_s mem_req, // Memory request
	output logic [7:0] mem_rdata // Read data
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;
	initial
	begin
		last = 8'h00;
		mem[16'h1ff8] = 8'hde;
		mem[16'h1ff9] = 8'hf0;
		mem[16'h1ffa] = 8'h9a;
		mem[16'h1ffb] = 8'hbc;
		mem[16'h1ffc] = 8'h56;
		mem[16'h1ffd] = 8'h78;
		mem[16'h1ffe] = 8'h12;
		mem[16'h1fff] = 8'h34;
	end
	always @(posedge pclk)
	begin
		if (mem_req.we === 1'b1)
			mem[mem_req.addr] <= mem_req.wdata;
		if (mem_req.re === 1'b1)
			last <= mem_rdata;
	end
	// Idle bus shows the inverted last byte
	always_comb
		mem_rdata = (mem_req.re === 1'b1) ? mem[mem_req.addr] : ~last;
endmodule

// [test/reset_and_interrupt_sequencer_tb.sv]
// Self-checking testbench for the reset and interrupt sequencer
`timescale 1ns/1ps
module reset_and_interrupt_sequencer_tb;
	import rst_irq_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, ext_reset_n = 1, irq_n = 1, mask_seen = 0, osc_running = 0;
	logic instr_done = 0, trap_instr = 0, return_instr = 0, stop_enter = 0, wait_enter = 0;
	logic [2:0] timer_flags = 3'h0, timer_enables = 3'h0;
	logic [7:0] mem_rdata, sp, wq[$];
	cpu_regs_s cpu_regs = '0, restore_regs;
	mem_req_s mem_req;
	reset_ctrl_s reset_ctrl;
	logic cpu_hold, mask_set, pc_load, restore_load, clocks_stopped, cpu_waiting;
	logic [15:0] new_pc;
	int n_mismatch = 0, checked = 0, cyc = 0, n;

	reset_and_interrupt_sequencer #(.WDOG_CYCLES(5000)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_running(osc_running),
		.ext_reset_n(ext_reset_n), .irq_n(irq_n), .rom_wdog_byte(8'h5a),
		.instr_done(instr_done), .trap_instr(trap_instr), .return_instr(return_instr),
		.cpu_regs(cpu_regs), .timer_flags(timer_flags), .timer_enables(timer_enables),
		.stop_enter(stop_enter), .wait_enter(wait_enter), .mem_rdata(mem_rdata),
		.mem_req(mem_req), .reset_ctrl(reset_ctrl), .cpu_hold(cpu_hold), .sp(sp),
		.mask_set(mask_set), .pc_load(pc_load), .new_pc(new_pc), .restore_load(restore_load),
		.restore_regs(restore_regs), .clocks_stopped(clocks_stopped), .cpu_waiting(cpu_waiting));
	cpu_mem_model mem (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	always #12.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (mem_req.we === 1'b1)
			wq.push_back(mem_req.wdata);
		if (mask_set === 1'b1)
			mask_seen <= 1'b1;
		if (cyc == 50000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	// ****
	// Helpers
	// ****
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task step(input logic t, input logic r);
		@(posedge pclk);
		instr_done <= 1'b1;
		trap_instr <= t;
		return_instr <= r;
		@(posedge pclk);
		instr_done <= 1'b0;
		trap_instr <= 1'b0;
		return_instr <= 1'b0;
	endtask

	task wait_pc(input logic [15:0] exp);
		n = 0;
		while (pc_load !== 1'b1 && n < 6000)
		begin
			@(posedge pclk);
			n++;
		end
		chk({16'h0, new_pc}, {16'h0, exp});
	endtask

	task cause(input logic [2:0] exp);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk({29'h0, rd[6:4]}, {29'h0, exp});
	endtask

	// ****
	// Scenarios
	// ****
	task t_por;
		@(posedge pclk);
		chk({29'h0, reset_ctrl.core_reset, reset_ctrl.ddr_clear, reset_ctrl.timer_clear}, 32'h7);
		chk({16'h0, reset_ctrl.timer_preset}, 32'hfffc);
		chk({23'h0, mask_set, sp}, 32'h1ff);
		repeat (100) @(posedge pclk);
		chk({30'h0, reset_ctrl.core_reset, cpu_hold}, 32'h3);
		osc_running <= 1'b1;
		wait_pc(16'h1234);
		chk({31'h0, n >= 4064 && n <= 4070}, 32'h1);
		apb(1'b0, WDOG_ADDR, 32'h0);
		chk(rd, 32'h5a);
		cause(CAUSE_POR);
		apb(1'b0, 16'h0100, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("Test por done");
	endtask

	task t_irq;
		apb(1'b1, WDOG_ADDR, 32'h0);
		cpu_regs <= {16'h4321, 8'h11, 8'h22, 8'h00};
		timer_flags <= 3'h1;
		timer_enables <= 3'h1;
		irq_n <= 1'b0;
		@(posedge pclk);
		irq_n <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk({30'h0, rd[1:0]}, 32'h3);
		irq_n <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({31'h0, cpu_hold}, 32'h0);
		wq.delete();
		mask_seen = 1'b0;
		step(1'b0, 1'b0);
		wait_pc(16'h9abc);
		chk({wq[0], wq[1], wq[2], wq[3]}, 32'h21431122);
		chk({16'h0, wq[4], sp}, 32'h00fa);
		chk({31'h0, mask_seen}, 32'h1);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		cpu_regs.condition_code_reg <= 8'h08;
		step(1'b0, 1'b1);
		n = 0;
		while (restore_load !== 1'b1 && n++ < 50)
			@(posedge pclk);
		chk({16'h0, restore_regs.pc}, 32'h4321);
		chk({restore_regs.x, restore_regs.a, restore_regs.condition_code_reg, sp}, 32'h112200ff);
		cpu_regs.condition_code_reg <= 8'h00;
		step(1'b0, 1'b0);
		wait_pc(16'h9abc);
		irq_n <= 1'b1;
		$display("Test irq done");
	endtask

	task t_timer;
		cpu_regs.condition_code_reg <= 8'h08;
		step(1'b0, 1'b0);
		repeat (2) @(posedge pclk);
		chk({31'h0, cpu_hold}, 32'h0);
		cpu_regs.condition_code_reg <= 8'h00;
		timer_enables <= 3'h4;
		step(1'b0, 1'b0);
		repeat (2) @(posedge pclk);
		chk({31'h0, cpu_hold}, 32'h0);
		timer_flags <= 3'h5;
		step(1'b0, 1'b0);
		wait_pc(16'hdef0);
		cpu_regs.condition_code_reg <= 8'h08;
		step(1'b1, 1'b0);
		wait_pc(16'h5678);
		$display("Test timer and trap done");
	endtask

	task t_ext;
		stop_enter <= 1'b1;
		wait_enter <= 1'b1;
		@(posedge pclk);
		stop_enter <= 1'b0;
		wait_enter <= 1'b0;
		@(posedge pclk);
		chk({30'h0, clocks_stopped, cpu_waiting}, 32'h3);
		ext_reset_n <= 1'b0;
		@(posedge pclk);
		ext_reset_n <= 1'b1;
		repeat (6) @(posedge pclk);
		chk({31'h0, reset_ctrl.core_reset}, 32'h0);
		ext_reset_n <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({29'h0, reset_ctrl.core_reset, reset_ctrl.ddr_clear, reset_ctrl.timer_clear}, 32'h7);
		chk({22'h0, sp, clocks_stopped, cpu_waiting}, 32'h3fc);
		ext_reset_n <= 1'b1;
		wait_pc(16'h1234);
		cause(CAUSE_EXT);
		$display("Test ext reset done");
	endtask

	task t_wdog;
		apb(1'b1, WDOG_ADDR, 32'h0);
		repeat (3)
		begin
			repeat (4000) @(posedge pclk);
			apb(1'b1, WDOG_ADDR, 32'h0);
		end
		chk({31'h0, reset_ctrl.core_reset}, 32'h0);
		n = 0;
		while (reset_ctrl.core_reset !== 1'b1 && n < 5500)
		begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, n > 4990 && n < 5010}, 32'h1);
		wait_pc(16'h1234);
		chk({31'h0, n >= 4063}, 32'h1);
		cause(CAUSE_WDOG);
		$display("Test watchdog done");
	endtask

	task end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_por();
		t_irq();
		t_timer();
		t_ext();
		t_wdog();
		end_sim();
	end
endmodule
